//--- logic/epcirq_pkg.sv
// package for the external request and pin change interrupt block
// assumes an 8-bit register map reached over a 32-bit APB slave
package epcirq_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] PCM_LOW_IDX  = 8'h12;  // pin_change_mask_low
  localparam logic [7:0] PCM_HIGH_IDX = 8'h20;  // pin_change_mask_high
  localparam logic [7:0] MCU_CTL_IDX  = 8'h35;  // mcu_control
  localparam logic [7:0] IEN_MASK_IDX = 8'h3b;  // interrupt_enable_mask
  localparam logic [7:0] IFLAGS_IDX   = 8'h3c;  // interrupt_flags
  localparam int         ADDR_W       = 10;     // byte address width
  localparam int         ADDR_LSB     = 2;      // word aligned

  // field positions
  localparam int SENSE_LO_BIT  = 0;  // sense_ctl_lo
  localparam int SENSE_HI_BIT  = 1;  // sense_ctl_hi
  localparam int GRP0_BIT      = 4;  // group0 enable / flag
  localparam int GRP1_BIT      = 5;  // group1 enable / flag
  localparam int EXT_BIT       = 6;  // ext request enable / flag
  localparam logic [7:0] ENFLAG_RW_MASK = 8'h70;  // bits 6..4 live
  localparam logic [7:0] PCM_HIGH_MASK  = 8'h0f;  // bits 3..0 live
  localparam logic [7:0] REG_RESET      = 8'h00;  // all registers

  // sense control encodings
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_ANY  = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // source numbering and dispatch addresses
  localparam int          SRC_EXT   = 0;
  localparam int          SRC_GRP0  = 1;
  localparam int          SRC_GRP1  = 2;
  localparam int          NSRC      = 3;
  localparam logic [15:0] VEC_EXT   = 16'h0001;
  localparam logic [15:0] VEC_GRP0  = 16'h0002;  // group0_vector
  localparam logic [15:0] VEC_GRP1  = 16'h0003;  // group1_vector
  localparam logic [15:0] VEC_NONE  = 16'h0000;

  localparam int LOW_PINS  = 8;
  localparam int HIGH_PINS = 4;

  // request bundle toward the core
  typedef struct packed {
    logic [NSRC-1:0] req;     // one line per source
    logic [15:0]     vector;  // address of the highest priority request
  } epcirq_core_req_t;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } epcirq_apb_req_t;

  // apb slave state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READY = 3'b010,
    ST_DONE  = 3'b100
  } epcirq_apb_st_t;

endpackage : epcirq_pkg

//--- logic/epcirq_sync.sv
// two flip-flop synchroniser for a bus of pin levels
// assumes a single clock; reset value is a constant
`timescale 1ns/100ps
`default_nettype none
module epcirq_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage1_reg;  // read only by the second stage

  // first stage may go metastable; nothing else looks at it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stage1_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
    end
  end

  // second stage is the clean level
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_sync <= '0;
    end else begin
      pin_sync <= stage1_reg;
    end
  end
endmodule : epcirq_sync
`default_nettype wire

//--- logic/epcirq_top.sv
// external request and pin change interrupt logic with APB registers
// assumes the core supplies its global flag and one acknowledge per
// source, and that pins are level inputs sampled on clock
// and that the bus master follows the two-phase apb handshake
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module epcirq_top (
  input  wire logic                         clock,
  input  wire logic                         nrst,
  // apb slave
  input  wire epcirq_pkg::epcirq_apb_req_t  apb_req,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  // pins
  input  wire logic                         ext_request_zero,
  input  wire logic [7:0]                   lower_group_pins,
  input  wire logic [3:0]                   upper_group_pins,
  // core side
  input  wire logic                         global_int_enable,
  input  wire logic [2:0]                   irq_ack,
  output epcirq_pkg::epcirq_core_req_t      core_req,
  output logic                              wake_req
);
  import epcirq_pkg::*;

  // software visible state
  logic [7:0]            pcm_low_reg;   // pin_change_mask_low
  logic [3:0]            pcm_high_reg;  // pin_change_mask_high live bits
  logic [7:0]            mcu_ctl_reg;   // mcu_control, all bits stored
  logic [2:0]            ien_reg;       // enables: grp1, grp0, ext
  logic [2:0]            flag_reg;      // flags: grp1, grp0, ext
  logic [2:0]            flag_next;     // next flag value
  epcirq_apb_st_t        st_reg;        // apb slave state
  epcirq_apb_st_t        st_next;

  // pin sampling
  logic                  ext_sync;      // synchronised request pin
  logic                  ext_prev_reg;  // previous sample
  logic [LOW_PINS-1:0]   low_sync;
  logic [LOW_PINS-1:0]   low_prev_reg;
  logic [HIGH_PINS-1:0]  high_sync;
  logic [HIGH_PINS-1:0]  high_prev_reg;
  logic [LOW_PINS-1:0]   low_diff;      // per-pin change, masked
  logic [HIGH_PINS-1:0]  high_diff;

  // event and bus strobes
  logic                  ext_event;     // edge matching sense mode
  logic                  level_mode;    // low level sensing selected
  logic                  wr_stb;        // write takes effect this edge
  logic [7:0]            wdata8;        // low byte of write data
  logic [7:0]            rd_byte;       // read multiplexer
  logic                  addr_ok;       // address maps a register
  logic [1:0]            sense;         // sense control field

  // true when the byte address selects the given register index
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
    addr_hit = (a[ADDR_W-1:ADDR_LSB] == idx) && (a[ADDR_LSB-1:0] == 2'h0);
  endfunction : addr_hit

  // true when the address maps any register
  function automatic logic addr_any(input logic [ADDR_W-1:0] a);
    addr_any = addr_hit(a, PCM_LOW_IDX) || addr_hit(a, PCM_HIGH_IDX)
            || addr_hit(a, MCU_CTL_IDX) || addr_hit(a, IEN_MASK_IDX)
            || addr_hit(a, IFLAGS_IDX);
  endfunction : addr_any

  // places the per-source bits at their register positions; source order
  // (ext, grp0, grp1) is not bit order (6, 4, 5), so both reads go here
  function automatic logic [7:0] src_to_byte(input logic [NSRC-1:0] v);
    src_to_byte           = 8'h00;
    src_to_byte[EXT_BIT]  = v[SRC_EXT];
    src_to_byte[GRP0_BIT] = v[SRC_GRP0];
    src_to_byte[GRP1_BIT] = v[SRC_GRP1];
  endfunction : src_to_byte

  assign wdata8     = apb_req.pwdata[7:0];
  assign sense      = {mcu_ctl_reg[SENSE_HI_BIT], mcu_ctl_reg[SENSE_LO_BIT]};
  assign level_mode = (sense == SENSE_LOW);
  assign addr_ok    = addr_any(apb_req.paddr);
  // write lands only at the completing access edge
  assign wr_stb     = apb_req.psel && apb_req.penable && pready
                   && apb_req.pwrite && addr_ok;

  // synchronisers; pins read regardless of port direction
  epcirq_sync #(.WIDTH(1)) u_sync_ext (
    .clock    (clock),
    .nrst     (nrst),
    .pin_in   (ext_request_zero),
    .pin_sync (ext_sync)
  );

  // all twelve pins share one synchroniser so they see equal delay
  epcirq_sync #(.WIDTH(LOW_PINS + HIGH_PINS)) u_sync_grp (
    .clock    (clock),
    .nrst     (nrst),
    .pin_in   ({upper_group_pins, lower_group_pins}),
    .pin_sync ({high_sync, low_sync})
  );

  // previous samples for edge and change detection
  // they reset to zero like the synchroniser, so a pin held high through
  // reset looks moved once, when its level reaches the second stage
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ext_prev_reg  <= 1'b0;
      low_prev_reg  <= '0;
      high_prev_reg <= '0;
    end else begin
      ext_prev_reg  <= ext_sync;
      low_prev_reg  <= low_sync;
      high_prev_reg <= high_sync;
    end
  end

  // per-pin difference gated by its mask bit
  generate
    for (genvar i = 0; i < LOW_PINS; i++) begin : g_low
      assign low_diff[i] = (low_sync[i] ^ low_prev_reg[i])
                         & pcm_low_reg[i];
    end
    for (genvar j = 0; j < HIGH_PINS; j++) begin : g_high
      assign high_diff[j] = (high_sync[j] ^ high_prev_reg[j])
                          & pcm_high_reg[j];
    end
  endgenerate

  // edge selection on the sampled request pin
  // low level needs no edge: its request comes straight from the synchronised pin
  always_comb begin
    case (sense)
      SENSE_ANY:  ext_event = ext_sync ^ ext_prev_reg;
      SENSE_FALL: ext_event = ext_prev_reg & ~ext_sync;
      SENSE_RISE: ext_event = ~ext_prev_reg & ext_sync;
      default:    ext_event = 1'b0;  // low level raises no flag
    endcase
  end

  // flag update: a set in the same cycle as a clear wins
  always_comb begin
    flag_next = flag_reg;
    // clear by acknowledge on vector entry
    flag_next = flag_next & ~irq_ack;
    // clear by writing one; zero leaves the bit alone
    if (wr_stb && addr_hit(apb_req.paddr, IFLAGS_IDX)) begin
      flag_next[SRC_EXT]  = flag_next[SRC_EXT]  & ~wdata8[EXT_BIT];
      flag_next[SRC_GRP0] = flag_next[SRC_GRP0] & ~wdata8[GRP0_BIT];
      flag_next[SRC_GRP1] = flag_next[SRC_GRP1] & ~wdata8[GRP1_BIT];
    end
    // sets; the enable does not gate the flag itself
    if (ext_event) begin
      flag_next[SRC_EXT] = 1'b1;
    end
    if (|low_diff) begin
      flag_next[SRC_GRP0] = 1'b1;
    end
    if (|high_diff) begin
      flag_next[SRC_GRP1] = 1'b1;
    end
    // level mode holds the ext flag cleared
    if (level_mode) begin
      flag_next[SRC_EXT] = 1'b0;
    end
  end

  // flag register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // mask registers
  // a mask change alone never sets a flag; only pin movement does
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pcm_low_reg  <= REG_RESET;
      pcm_high_reg <= REG_RESET[3:0];
    end else if (wr_stb) begin
      if (addr_hit(apb_req.paddr, PCM_LOW_IDX)) begin
        pcm_low_reg <= wdata8;
      end
      if (addr_hit(apb_req.paddr, PCM_HIGH_IDX)) begin
        pcm_high_reg <= wdata8[3:0];  // upper bits not stored
      end
    end
  end

  // control and enable registers
  // the enable bits are stored in source order, not register order
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mcu_ctl_reg <= REG_RESET;
      ien_reg     <= '0;
    end else if (wr_stb) begin
      if (addr_hit(apb_req.paddr, MCU_CTL_IDX)) begin
        // sleep and pull-up bits are kept but steer nothing here
        mcu_ctl_reg <= wdata8;
      end
      if (addr_hit(apb_req.paddr, IEN_MASK_IDX)) begin
        ien_reg <= {wdata8[GRP1_BIT], wdata8[GRP0_BIT], wdata8[EXT_BIT]};
      end
    end
  end

  // read multiplexer; reserved bits come back as zero
  // unmapped addresses fall through to zero and answer with pslverr
  always_comb begin
    rd_byte = 8'h00;
    if (addr_hit(apb_req.paddr, PCM_LOW_IDX)) begin
      rd_byte = pcm_low_reg;
    end else if (addr_hit(apb_req.paddr, PCM_HIGH_IDX)) begin
      rd_byte = {4'h0, pcm_high_reg} & PCM_HIGH_MASK;
    end else if (addr_hit(apb_req.paddr, MCU_CTL_IDX)) begin
      rd_byte = mcu_ctl_reg;
    end else if (addr_hit(apb_req.paddr, IEN_MASK_IDX)) begin
      rd_byte = src_to_byte(ien_reg) & ENFLAG_RW_MASK;
    end else if (addr_hit(apb_req.paddr, IFLAGS_IDX)) begin
      rd_byte = src_to_byte(flag_reg) & ENFLAG_RW_MASK;
    end
  end

  // apb slave: no wait state, answer registered for the access phase
  always_comb begin
    case (st_reg)
      ST_IDLE: begin
        // setup cycle seen: ready in the following access cycle
        st_next = (apb_req.psel && !apb_req.penable) ? ST_READY : ST_IDLE;
      end
      ST_READY: begin
        st_next = ST_DONE;  // access completes at this edge
      end
      ST_DONE: begin
        // back-to-back setup may follow directly
        st_next = (apb_req.psel && !apb_req.penable) ? ST_READY : ST_IDLE;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  // state register
  // a state outside the three one-hot codes falls back to idle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_reg <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // answer outputs, all from flops
  // read data is captured at the setup edge; a flag that sets during
  // the access cycle shows on the next read
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (st_next == ST_READY) begin
      pready  <= 1'b1;
      pslverr <= !addr_ok;  // unmapped address answers with an error
      prdata  <= (apb_req.pwrite || !addr_ok) ? 32'h0000_0000
                                               : {24'h00_0000, rd_byte};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
  end

  // request lines toward the core
  // one line per source lets the core pick its own priority; the
  // vector gives the fixed order for a core that wants only one
  always_ff @(posedge clock) begin
    if (!nrst) begin
      core_req <= '0;
    end else begin
      // level mode asks while the synced pin is low; the driver must
      // hold it until the current instruction ends
      core_req.req[SRC_EXT] <= global_int_enable && ien_reg[SRC_EXT]
                            && (level_mode ? !ext_sync
                                           : flag_next[SRC_EXT]);
      core_req.req[SRC_GRP0] <= global_int_enable && ien_reg[SRC_GRP0]
                             && flag_next[SRC_GRP0];
      core_req.req[SRC_GRP1] <= global_int_enable && ien_reg[SRC_GRP1]
                             && flag_next[SRC_GRP1];
      // fixed priority: lowest address first
      if (global_int_enable && ien_reg[SRC_EXT]
          && (level_mode ? !ext_sync : flag_next[SRC_EXT])) begin
        core_req.vector <= VEC_EXT;
      end else if (global_int_enable && ien_reg[SRC_GRP0]
                   && flag_next[SRC_GRP0]) begin
        core_req.vector <= VEC_GRP0;
      end else if (global_int_enable && ien_reg[SRC_GRP1]
                   && flag_next[SRC_GRP1]) begin
        core_req.vector <= VEC_GRP1;
      end else begin
        core_req.vector <= VEC_NONE;
      end
    end
  end

  // wake indication: needs neither the global flag nor edge logic, so
  // a sleep controller can restart the clock; a true clockless path
  // would sit in the pad ring, this is its clocked stand-in
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= (|low_diff && ien_reg[SRC_GRP0])
               || (|high_diff && ien_reg[SRC_GRP1])
               || (level_mode && ien_reg[SRC_EXT] && !ext_sync);
    end
  end

endmodule : epcirq_top
`default_nettype wire

//--- verif/epcirq_checker.sv
// assertion checker for the external request and pin change block
// assumes it is bound to epcirq_top and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module epcirq_checker (
  input wire logic                        clock,
  input wire logic                        nrst,
  input wire epcirq_pkg::epcirq_apb_req_t apb_req,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [7:0]                  lower_group_pins,
  input wire logic [3:0]                  upper_group_pins,
  input wire logic                        global_int_enable,
  input wire logic [2:0]                  irq_ack,
  input wire epcirq_pkg::epcirq_core_req_t core_req
);
  import epcirq_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // a group change is seen three edges before its flag and request rise
  sequence s_g0_moved;
    $past(lower_group_pins, 3) != $past(lower_group_pins, 4);
  endsequence
  sequence s_g1_moved;
    $past(upper_group_pins, 3) != $past(upper_group_pins, 4);
  endsequence
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready in the access cycle");
  a_slverr_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without ready or with data");
  a_req_needs_gie: assert property (!$past(global_int_enable) |-> core_req.req == 3'h0)
    else $error("request raised without global flag");
  a_vec_ext: assert property (core_req.req[0] |-> core_req.vector == VEC_EXT)
    else $error("wrong vector for ext request");
  a_vec_grp0: assert property (core_req.req[1:0] == 2'b10 |-> core_req.vector == VEC_GRP0)
    else $error("wrong vector for group0");
  a_vec_grp1: assert property (core_req.req == 3'b100 |-> core_req.vector == VEC_GRP1)
    else $error("wrong vector for group1");
  a_ack_clears: assert property ((|irq_ack[2:1]) |=> (core_req.req[2:1] & $past(irq_ack[2:1])) == 2'h0)
    else $error("request stays after acknowledge");
  a_grp0_cause: assert property ($rose(core_req.req[1]) && $past(global_int_enable, 2) |-> s_g0_moved)
    else $error("group0 request without pin change");
  a_grp1_cause: assert property ($rose(core_req.req[2]) && $past(global_int_enable, 2) |-> s_g1_moved)
    else $error("group1 request without pin change");
  a_resv_read_zero: assert property (pready && !apb_req.pwrite && apb_req.paddr[9:2] >= IEN_MASK_IDX
    |-> prdata[7] == 1'b0 && prdata[3:0] == 4'h0)
    else $error("reserved bits read non-zero");
  a_high_mask_zero: assert property (pready && !apb_req.pwrite && apb_req.paddr[9:2] == PCM_HIGH_IDX
    |-> prdata[7:4] == 4'h0)
    else $error("upper mask bits read non-zero");
endmodule : epcirq_checker
bind epcirq_top epcirq_checker chk_u (
  .clock(clock), .nrst(nrst), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .lower_group_pins(lower_group_pins), .upper_group_pins(upper_group_pins),
  .global_int_enable(global_int_enable), .irq_ack(irq_ack), .core_req(core_req));
`default_nettype wire

//--- verif/epcirq_core_model.sv
// core model: enters one routine at a time after a chosen delay
// assumes the request bundle of epcirq_top and a bench-set delay
`timescale 1ns/100ps
`default_nettype none
module epcirq_core_model (
  input  wire logic                         clock,
  input  wire logic                         nrst,
  input  wire epcirq_pkg::epcirq_core_req_t core_req,
  input  wire logic [2:0]                   ack_delay,
  output logic      [2:0]                   irq_ack,
  output logic      [15:0]                  last_vec,
  output logic      [7:0]                   takes
);
  import epcirq_pkg::*;
  logic [2:0] wait_reg;  // cycles the pending request has waited
  // entering a routine acknowledges the source it vectors to
  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_ack  <= 3'h0;
      wait_reg <= 3'h0;
      last_vec <= VEC_NONE;
      takes    <= 8'h00;
    end else if (irq_ack != 3'h0 || core_req.req == 3'h0) begin
      irq_ack  <= 3'h0;  // pulse, and skip the cycle the request drops in
      wait_reg <= 3'h0;
    end else if (wait_reg < ack_delay) begin
      wait_reg <= wait_reg + 3'h1;  // slow core: let the request stand
    end else begin
      irq_ack  <= 3'h1 << (core_req.vector[1:0] - 2'h1);
      last_vec <= core_req.vector;
      takes    <= takes + 8'h01;
    end
  end
endmodule : epcirq_core_model
`default_nettype wire

//--- verif/epcirq_tb.sv
// self-checking bench for the external request and pin change block
// assumes epcirq_top and the core model; apb master lives here
`timescale 1ns/100ps
`default_nettype none
module epcirq_tb;
  import epcirq_pkg::*;
  logic             clock, nrst, ext_pin, gie, pready, pslverr, wake_req, err;
  logic [7:0]       lo_pins, rd, e, w, t0, t1, m0, m1, n0;
  logic [3:0]       hi_pins;
  logic [2:0]       irq_ack, ack_delay;
  logic [31:0]      prdata;
  logic [15:0]      last_vec;
  logic [7:0]       takes;
  epcirq_apb_req_t  apb_req;
  epcirq_core_req_t core_req;
  int               err_total, checks;
  logic [7:0] idx_tab [5] = '{PCM_LOW_IDX, PCM_HIGH_IDX, MCU_CTL_IDX, IEN_MASK_IDX, IFLAGS_IDX};
  logic [7:0] msk_tab [5] = '{8'hff, PCM_HIGH_MASK, 8'hff, ENFLAG_RW_MASK, 8'h00};
  logic [15:0] vec_tab [3] = '{VEC_EXT, VEC_GRP0, VEC_GRP1};
  epcirq_top dut_u (.clock(clock), .nrst(nrst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_request_zero(ext_pin),
    .lower_group_pins(lo_pins), .upper_group_pins(hi_pins), .global_int_enable(gie),
    .irq_ack(irq_ack), .core_req(core_req), .wake_req(wake_req));
  epcirq_core_model model_u (.clock(clock), .nrst(nrst), .core_req(core_req),
    .ack_delay(ack_delay), .irq_ack(irq_ack), .last_vec(last_vec), .takes(takes));
  // free-running 10 mhz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {24'h0, wd}};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    n = 0;
    // pready is looked at from the first access edge on, never at the
    // edge that raises penable
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;  // a hung slave counts as a mismatch
    end
    rd  = prdata[7:0];
    err = pslverr;
    apb_req <= '0;
  endtask : apb
  function automatic logic ext_hit(input logic [1:0] m, input logic lvl);
    return m == SENSE_ANY || m == (lvl ? SENSE_RISE : SENSE_FALL);
  endfunction : ext_hit
  // one step of the request pin with the global flag low
  task automatic pin_step(input logic [1:0] m, input logic lvl);
    apb(1'b1, IFLAGS_IDX, 8'h70);
    ext_pin <= lvl;  // held six cycles, past the current instruction
    repeat (6) @(posedge clock);
    apb(1'b0, IFLAGS_IDX, 8'h00);
    chk("ext_flag", rd, {1'b0, ext_hit(m, lvl), 6'h0});
    chk("ext_req", core_req.req[0], 1'b0);
    chk("wake", wake_req, m == SENSE_LOW && !lvl);
  endtask : pin_step
  task automatic conclude();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    err_total++;
    conclude();
  end
  initial begin
    {nrst, gie, ext_pin, lo_pins, hi_pins, ack_delay} = '0;
    apb_req = '0;
    ext_pin = 1'b1;
    void'($urandom(32'h92d2));
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    // reset values, then a hole in the map
    foreach (idx_tab[i]) begin
      apb(1'b0, idx_tab[i], 8'h00);
      chk("reset", rd, REG_RESET);
    end
    apb(1'b0, 8'h01, 8'h00);
    chk("slverr", err, 1'b1);
    // every sense mode, falling then rising step
    apb(1'b1, IEN_MASK_IDX, 8'h70);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, MCU_CTL_IDX, 8'(m));
      pin_step(2'(m), 1'b0);
      pin_step(2'(m), 1'b1);
    end
    apb(1'b1, IFLAGS_IDX, 8'h70);  // drop flags left by the sense steps
    // random writes read back through the live bits only
    foreach (idx_tab[i]) begin
      e = 8'($urandom);
      apb(1'b1, idx_tab[i], e);
      apb(1'b0, idx_tab[i], 8'h00);
      chk("rw", rd, e & msk_tab[i]);
    end
    // masked pin changes, flags cleared by writing ones
    for (int k = 0; k < 8; k++) begin
      {m0, m1, t0, t1, w} = {$urandom, 8'($urandom)};
      if (k == 0) {m0, m1, t0, t1} = 32'h00f0ffff;  // all masked off
      apb(1'b1, PCM_LOW_IDX, m0);
      apb(1'b1, PCM_HIGH_IDX, m1);
      apb(1'b1, IFLAGS_IDX, 8'h70);
      lo_pins <= lo_pins ^ t0;
      hi_pins <= hi_pins ^ t1[3:0];
      repeat (6) @(posedge clock);
      e = {2'b00, |(t1[3:0] & m1[3:0]), |(t0 & m0), 4'h0};
      apb(1'b1, IFLAGS_IDX, w);
      apb(1'b0, IFLAGS_IDX, 8'h00);
      chk("grp_flags", rd, e & ~w);
    end
    // dispatch of each source with a prompt or slow core
    apb(1'b1, IEN_MASK_IDX, 8'h70);  // random writes left the enables unknown
    apb(1'b1, PCM_LOW_IDX, 8'hff);
    apb(1'b1, PCM_HIGH_IDX, 8'h0f);
    apb(1'b1, MCU_CTL_IDX, {6'h0, SENSE_FALL});
    apb(1'b1, IFLAGS_IDX, 8'h70);
    gie <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      n0 = takes;
      ack_delay <= 3'($urandom);
      if (s == 0) ext_pin <= 1'b0;
      if (s == 1) lo_pins <= lo_pins ^ (8'h01 << $urandom_range(7));
      if (s == 2) hi_pins <= hi_pins ^ 4'h8;
      repeat (20) @(posedge clock);
      chk("takes", takes, n0 + 8'h01);
      chk("vector", last_vec, vec_tab[s]);
      apb(1'b0, IFLAGS_IDX, 8'h00);
      chk("flags_after", rd, 8'h00);
    end
    conclude();
  end
endmodule : epcirq_tb
`default_nettype wire
